// File: logic/csw_pkg.sv
package csw_pkg;
  // ----------------------------------------------------------------
  // bus addressing and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CSW_SLAVE_ADDR = 7'h09;       // preset slave address
  localparam logic [7:0] CSW_CMD_CURRENT = 8'h14;      // current_setpoint word
  localparam logic [7:0] CSW_CMD_VOLTAGE = 8'h15;      // voltage_setpoint word
  localparam logic [7:0] CSW_CMD_INPUT = 8'h3f;        // input current limit word
  localparam logic [7:0] CSW_CMD_STATE_DEF = 8'h13;    // charger_state_word, default only
  // ----------------------------------------------------------------
  // reset values and limits (mA / mV codes)
  // ----------------------------------------------------------------
  localparam logic [15:0] CSW_CURRENT_RST = 16'h0080;  // 128 mA
  localparam logic [15:0] CSW_INPUT_RST = 16'h0100;    // 256 mA
  localparam logic [15:0] CSW_VOLTAGE_RST = 16'h0000;  // no charge voltage
  localparam logic [15:0] CSW_UV_CURRENT = 16'h0080;   // 128 mA compliance under battery uv
  localparam logic [15:0] CSW_VOLTAGE_MIN = 16'h0400;  // 1024 mV, lowest nonzero setting
  localparam logic [15:0] CSW_WORD_ZERO = 16'h0000;
  // ----------------------------------------------------------------
  // state word fields and bit counting
  // ----------------------------------------------------------------
  localparam int CSW_BIT_ADAPTER = 15;                 // adapter_present_flag
  localparam int CSW_BIT_BATTERY = 14;                 // battery connected
  localparam int CSW_BIT_PFAIL = 13;                   // power fail
  localparam logic [2:0] CSW_BIT_LAST = 3'h7;          // last bit of a byte
  localparam logic [2:0] CSW_BIT_FIRST = 3'h0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic adapter_above;       // adapter_input above presence threshold
    logic adapter_below_battery_voltage_sense;  // adapter_input below battery plus margin
    logic thermistor_low;      // thermistor_input below fraction of logic supply
    logic battery_voltage_sense_below_uv;       // battery_voltage_sense below undervoltage level
    logic battery_voltage_sense_above_release;  // battery_voltage_sense above release level
    logic logic_supply_uv;     // logic supply below its threshold
  } csw_cmp_type;

  typedef enum logic [2:0] {
    CSW_IDLE = 3'b000,
    CSW_ADDR = 3'b001,
    CSW_CMD = 3'b010,
    CSW_WLO = 3'b011,
    CSW_WHI = 3'b100,
    CSW_RLO = 3'b101,
    CSW_RHI = 3'b110,
    CSW_DONE = 3'b111
  } csw_state_type;
endpackage : csw_pkg

// File: logic/csw_charger.sv
`timescale 1ns/1ps
module csw_charger #(
  parameter logic [7:0] STATE_CMD = csw_pkg::CSW_CMD_STATE_DEF  // state word command code
) (
  input wire logic clk_sys_in,                     // charger control clock
  input wire logic reset_in,                       // async, active high
  input wire csw_pkg::csw_cmp_type cmp_in,         // comparator levels, asynchronous
  input wire logic smb_clk_in,                     // bus sampling clock
  input wire logic scl_in,                         // bus clock line level
  input wire logic sda_in,                         // bus data line level
  output logic sda_out,                            // level driven when enabled
  output logic sda_oe_out,                         // high while pulling data low
  output logic adapter_present_flag_out,           // adapter present
  output logic source_switch_gate_out,             // high turns source switch on
  output logic charge_enable_out,                  // charging permitted
  output logic [15:0] effective_current_out,       // current used by the converter
  output logic [15:0] current_setpoint_out,        // stored charge current
  output logic [15:0] voltage_setpoint_out,        // stored charge voltage
  output logic [15:0] input_limit_out,             // stored input current limit
  output logic [15:0] charger_state_word_out       // state word as seen by the bus
);
  import csw_pkg::*;

  // ----------------------------------------------------------------
  // system domain: comparator synchroniser and state word
  // ----------------------------------------------------------------
  csw_cmp_type cmp_m_q;           // first stage, read by second only
  csw_cmp_type cmp_s_q;           // synchronised comparator levels
  logic [15:0] state_word_q;      // charger_state_word
  logic clamp_q;                  // battery undervoltage clamp active
  logic [15:0] cur_q;             // system copy of current_setpoint
  logic [15:0] volt_q;            // system copy of voltage_setpoint
  logic [15:0] inlim_q;           // system copy of input limit
  logic gate_q;
  logic enable_q;
  logic [15:0] eff_q;
  logic wr_m_q, wr_s_q, wr_p_q;   // write toggle crossing
  logic wr_seen;                  // one-cycle: a bus write has arrived
  logic uv_s;
  // bus-side copies and write hand-off, declared early: the read mux names the copies, both domains the hand-off
  logic [15:0] cur_l_q, volt_l_q, inlim_l_q;   // bus-side setpoint registers
  logic wr_tgl_q;                 // flips once per committed write
  logic [7:0] wr_cmd_q;           // command of the last write, held until the next
  logic [15:0] wr_data_q;         // data of the last write, held until the next

  // comparator levels come from the analog side, two flops before use
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cmp_m_q <= '0;
      cmp_s_q <= '0;
    end else begin
      cmp_m_q <= cmp_in;
      cmp_s_q <= cmp_m_q;
    end
  end

  assign uv_s = cmp_s_q.logic_supply_uv;

  // state word bits follow the comparators; unused bits read zero
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_word_q <= CSW_WORD_ZERO;
    end else begin
      state_word_q <= CSW_WORD_ZERO;
      state_word_q[CSW_BIT_ADAPTER] <= cmp_s_q.adapter_above;
      state_word_q[CSW_BIT_BATTERY] <= cmp_s_q.thermistor_low;
      state_word_q[CSW_BIT_PFAIL] <= cmp_s_q.adapter_below_battery_voltage_sense;
    end
  end

  // ----------------------------------------------------------------
  // system domain: battery undervoltage clamp with hysteresis
  // ----------------------------------------------------------------
  // two comparators give the hysteresis; between them the clamp holds
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      clamp_q <= 1'b0;
    end else if (cmp_s_q.battery_voltage_sense_below_uv) begin
      clamp_q <= 1'b1;
    end else if (cmp_s_q.battery_voltage_sense_above_release) begin
      clamp_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // system domain: setpoint copies fed by the bus side
  // ----------------------------------------------------------------
  // toggle crossing; the bus side holds command and data until the next
  // write, which is many bus bits away, so the words are stable here
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wr_m_q <= 1'b0;
      wr_s_q <= 1'b0;
      wr_p_q <= 1'b0;
    end else begin
      wr_m_q <= wr_tgl_q;
      wr_s_q <= wr_m_q;
      wr_p_q <= wr_s_q;
    end
  end

  assign wr_seen = wr_s_q ^ wr_p_q;

  // clamp never touches these; only writes and supply loss do
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cur_q <= CSW_CURRENT_RST;
      volt_q <= CSW_VOLTAGE_RST;
      inlim_q <= CSW_INPUT_RST;
    end else if (uv_s) begin
      cur_q <= CSW_CURRENT_RST;
      volt_q <= CSW_VOLTAGE_RST;
      inlim_q <= CSW_INPUT_RST;
    end else if (wr_seen) begin
      if (wr_cmd_q == CSW_CMD_CURRENT) begin
        cur_q <= wr_data_q;
      end else if (wr_cmd_q == CSW_CMD_VOLTAGE) begin
        volt_q <= wr_data_q;
      end else if (wr_cmd_q == CSW_CMD_INPUT) begin
        inlim_q <= wr_data_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: charge control outputs
  // ----------------------------------------------------------------
  // charge needs adapter, enough headroom, logic supply and a voltage
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      gate_q <= 1'b0;
      enable_q <= 1'b0;
      eff_q <= CSW_CURRENT_RST;
    end else begin
      gate_q <= cmp_s_q.adapter_above & ~cmp_s_q.adapter_below_battery_voltage_sense;
      enable_q <= cmp_s_q.adapter_above & ~cmp_s_q.adapter_below_battery_voltage_sense
                  & ~uv_s & (volt_q >= CSW_VOLTAGE_MIN);
      eff_q <= clamp_q ? CSW_UV_CURRENT : cur_q;
    end
  end

  assign adapter_present_flag_out = state_word_q[CSW_BIT_ADAPTER];
  assign source_switch_gate_out = gate_q;
  assign charge_enable_out = enable_q;
  assign effective_current_out = eff_q;
  assign current_setpoint_out = cur_q;
  assign voltage_setpoint_out = volt_q;
  assign input_limit_out = inlim_q;
  assign charger_state_word_out = state_word_q;

  // ----------------------------------------------------------------
  // bus domain: line and level synchronisers
  // ----------------------------------------------------------------
  // this side runs on its own clock and the logic supply only, so it
  // stays usable with the adapter absent
  logic scl_m_q, scl_s_q, scl_p_q;   // clock line stages
  logic sda_m_q, sda_s_q, sda_p_q;   // data line stages
  logic uv_m_q, uv_l_q;              // logic supply uv in this domain
  logic [15:0] sw_m_q, sw_l_q;       // state word levels in this domain
  logic scl_rise, scl_fall, start_seen, stop_seen, byte_end;

  always_ff @(posedge smb_clk_in or posedge reset_in) begin
    if (reset_in) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      uv_m_q <= 1'b0;
      uv_l_q <= 1'b0;
      sw_m_q <= CSW_WORD_ZERO;
      sw_l_q <= CSW_WORD_ZERO;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      uv_m_q <= cmp_in.logic_supply_uv;
      uv_l_q <= uv_m_q;
      sw_m_q <= state_word_q;
      sw_l_q <= sw_m_q;
    end
  end

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_seen = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_seen = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------------------------------
  // bus domain: read word / write word slave
  // ----------------------------------------------------------------
  csw_state_type state_q;
  logic [2:0] cnt_q;          // bit position in the byte
  logic [7:0] shreg_q;        // received bits, msb first
  logic [15:0] tx_q;          // outgoing low byte then high byte
  logic byte_done_q;          // eighth bit taken, ack slot follows
  logic ack_phase_q;          // inside an ack slot
  logic oe_q;
  logic [7:0] cmd_q;
  logic cmd_valid_q;
  logic [7:0] lo_q;
  logic [15:0] rd_word;
  logic cmd_known;

  assign byte_end = scl_fall & byte_done_q;
  assign cmd_known = (shreg_q == CSW_CMD_CURRENT) | (shreg_q == CSW_CMD_VOLTAGE)
                     | (shreg_q == CSW_CMD_INPUT) | (shreg_q == STATE_CMD);

  // read word source by command
  always_comb begin
    if (cmd_q == STATE_CMD) begin
      rd_word = sw_l_q;
    end else if (cmd_q == CSW_CMD_CURRENT) begin
      rd_word = cur_l_q;
    end else if (cmd_q == CSW_CMD_VOLTAGE) begin
      rd_word = volt_l_q;
    end else if (cmd_q == CSW_CMD_INPUT) begin
      rd_word = inlim_l_q;
    end else begin
      rd_word = CSW_WORD_ZERO;
    end
  end

  // protocol engine; the data line is released in every ack slot that
  // belongs to the master, and a read only follows a command byte
  always_ff @(posedge smb_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= CSW_IDLE;
      cnt_q <= CSW_BIT_FIRST;
      shreg_q <= 8'h00;
      tx_q <= CSW_WORD_ZERO;
      byte_done_q <= 1'b0;
      ack_phase_q <= 1'b0;
      oe_q <= 1'b0;
      cmd_q <= 8'h00;
      cmd_valid_q <= 1'b0;
      lo_q <= 8'h00;
    end else if (uv_l_q) begin
      state_q <= CSW_IDLE;
      byte_done_q <= 1'b0;
      ack_phase_q <= 1'b0;
      oe_q <= 1'b0;
      cmd_valid_q <= 1'b0;
    end else if (start_seen) begin
      state_q <= CSW_ADDR;
      cnt_q <= CSW_BIT_FIRST;
      byte_done_q <= 1'b0;
      ack_phase_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (stop_seen) begin
      state_q <= CSW_IDLE;
      cmd_valid_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (state_q == CSW_IDLE) begin
      oe_q <= 1'b0;                                    // not addressed
    end else if (scl_rise && !ack_phase_q) begin
      shreg_q <= {shreg_q[6:0], sda_s_q};
      cnt_q <= cnt_q + 3'h1;
      byte_done_q <= (cnt_q == CSW_BIT_LAST);
    end else if (byte_end) begin
      byte_done_q <= 1'b0;
      ack_phase_q <= 1'b1;
      cnt_q <= CSW_BIT_FIRST;
      oe_q <= 1'b0;
      case (state_q)
        CSW_ADDR: begin
          // any master may address us, battery or host alike
          if (shreg_q[7:1] != CSW_SLAVE_ADDR) begin
            state_q <= CSW_DONE;
          end else if (!shreg_q[0]) begin
            state_q <= CSW_CMD;
            oe_q <= 1'b1;
          end else if (cmd_valid_q) begin
            state_q <= CSW_RLO;
            tx_q <= {rd_word[7:0], rd_word[15:8]};
            oe_q <= 1'b1;
          end else begin
            state_q <= CSW_DONE;                       // read without command
          end
        end
        CSW_CMD: begin
          cmd_q <= shreg_q;
          cmd_valid_q <= cmd_known;
          state_q <= cmd_known ? CSW_WLO : CSW_DONE;
          oe_q <= cmd_known;
        end
        CSW_WLO: begin
          lo_q <= shreg_q;
          state_q <= CSW_WHI;
          oe_q <= 1'b1;
        end
        CSW_WHI: begin
          state_q <= CSW_DONE;
          oe_q <= 1'b1;
        end
        CSW_RLO: begin
          state_q <= CSW_RHI;                          // master acks low byte
        end
        default: begin
          state_q <= CSW_DONE;                         // high byte nacked
        end
      endcase
    end else if (scl_fall && ack_phase_q) begin
      ack_phase_q <= 1'b0;
      if (state_q == CSW_RLO || state_q == CSW_RHI) begin
        oe_q <= ~tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end else begin
        oe_q <= 1'b0;
      end
    end else if (scl_fall && (state_q == CSW_RLO || state_q == CSW_RHI)) begin
      oe_q <= ~tx_q[15];
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;

  // ----------------------------------------------------------------
  // bus domain: bus-side setpoint registers and write hand-off
  // ----------------------------------------------------------------
  // kept here so reads answer locally without crossing back
  logic commit;

  assign commit = byte_end & (state_q == CSW_WHI);

  // the state word command is read-only; a write to it is acked, dropped
  always_ff @(posedge smb_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cur_l_q <= CSW_CURRENT_RST;
      volt_l_q <= CSW_VOLTAGE_RST;
      inlim_l_q <= CSW_INPUT_RST;
      wr_tgl_q <= 1'b0;
      wr_cmd_q <= 8'h00;
      wr_data_q <= CSW_WORD_ZERO;
    end else if (uv_l_q) begin
      cur_l_q <= CSW_CURRENT_RST;
      volt_l_q <= CSW_VOLTAGE_RST;
      inlim_l_q <= CSW_INPUT_RST;
    end else if (commit) begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_cmd_q <= cmd_q;
      wr_data_q <= {shreg_q, lo_q};
      if (cmd_q == CSW_CMD_CURRENT) begin
        cur_l_q <= {shreg_q, lo_q};
      end else if (cmd_q == CSW_CMD_VOLTAGE) begin
        volt_l_q <= {shreg_q, lo_q};
      end else if (cmd_q == CSW_CMD_INPUT) begin
        inlim_l_q <= {shreg_q, lo_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_adapter_bit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cmp_s_q.adapter_above |=> state_word_q[CSW_BIT_ADAPTER] && adapter_present_flag_out)
    else $error("adapter present not reflected");
  a_pfail_source_off: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cmp_s_q.adapter_below_battery_voltage_sense |=> !source_switch_gate_out && state_word_q[CSW_BIT_PFAIL])
    else $error("power fail left source on");
  a_battery_bit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(cmp_s_q.thermistor_low) |=> state_word_q[CSW_BIT_BATTERY])
    else $error("battery bit not set");
  a_uv_clamp: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cmp_s_q.battery_voltage_sense_below_uv |=> ##1 effective_current_out == CSW_UV_CURRENT)
    else $error("current not clamped");
  a_keep_setpoint: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(clamp_q) && !$past(wr_seen) && !$past(uv_s) |-> $stable(cur_q) && $stable(inlim_q))
    else $error("clamp changed a setpoint");
  a_release_hyst: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    clamp_q && !cmp_s_q.battery_voltage_sense_above_release |=> clamp_q)
    else $error("clamp released early");
  a_volt_untouched: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $changed(volt_q) |-> $past(wr_seen) || $past(uv_s))
    else $error("voltage setpoint changed by itself");
  a_uv_silent: assert property (@(posedge smb_clk_in) disable iff (reset_in)
    uv_l_q |=> !sda_oe_out [*2])
    else $error("bus answered under supply loss");
  a_uv_defaults: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    uv_s |=> cur_q == CSW_CURRENT_RST && inlim_q == CSW_INPUT_RST && volt_q == CSW_VOLTAGE_RST)
    else $error("defaults not restored");
  a_uv_inhibit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    uv_s |=> !charge_enable_out)
    else $error("charging under supply loss");
  a_ack_only_mine: assert property (@(posedge smb_clk_in) disable iff (reset_in)
    byte_end && state_q == CSW_ADDR && shreg_q[7:1] != CSW_SLAVE_ADDR |=> !sda_oe_out)
    else $error("acked a foreign address");

  c_clamp_enter: cover property (@(posedge clk_sys_in) disable iff (reset_in) $rose(clamp_q));
  c_write_word: cover property (@(posedge smb_clk_in) disable iff (reset_in) commit);
  c_read_word: cover property (@(posedge smb_clk_in) disable iff (reset_in)
    byte_end && state_q == CSW_ADDR && shreg_q[0] && cmd_valid_q);
  c_power_fail: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    $fell(source_switch_gate_out));
endmodule : csw_charger

// File: bench/csw_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus master model: owns scl, only ever pulls sda low
// ----------------------------------------------------------------
module csw_host_model (
  input wire logic clk_in,     // bench clock, lines move on its falling edge
  input wire logic sda_in,     // resolved data line, pull-up when released
  output logic scl_out,        // idles high, no free run between frames
  output logic sda_low_out     // high while pulling data low
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // quarter bit, far slower than the sampling clock needs
  task automatic qw;
    repeat (26) @(negedge clk_in);
  endtask : qw
  // start and repeated start: data falls while clock is high
  task automatic start;
    sda_low_out = 1'b0;
    qw();
    scl_out = 1'b1;
    qw();
    sda_low_out = 1'b1;
    qw();
    scl_out = 1'b0;
    qw();
  endtask : start
  // one bit: data set in clock low, sampled mid clock high
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    qw();
    scl_out = 1'b1;
    qw();
    r = sda_in;
    qw();
    scl_out = 1'b0;
    qw();
  endtask : bit_io
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] b, input logic m, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(m, a);
  endtask : xfer
  task automatic stop;
    sda_low_out = 1'b1;
    qw();
    scl_out = 1'b1;
    qw();
    sda_low_out = 1'b0;
    qw();
  endtask : stop
  // write word: address, command, low byte, high byte, each acked
  task automatic write_word(input logic [6:0] ad, input logic [7:0] c,
                            input logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic [3:0] a;
    start();
    xfer({ad, 1'b0}, 1'b1, r, a[0]);
    xfer(c, 1'b1, r, a[1]);
    xfer(d[7:0], 1'b1, r, a[2]);
    xfer(d[15:8], 1'b1, r, a[3]);
    stop();
    ok = (a === 4'h0);
  endtask : write_word
  // read word: command, repeated start, low byte acked, high byte not
  task automatic read_word(input logic [6:0] ad, input logic [7:0] c,
                           output logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic [2:0] a;
    logic n;
    start();
    xfer({ad, 1'b0}, 1'b1, r, a[0]);
    xfer(c, 1'b1, r, a[1]);
    start();
    xfer({ad, 1'b1}, 1'b1, r, a[2]);
    xfer(8'hff, 1'b0, d[7:0], n);
    xfer(8'hff, 1'b1, d[15:8], n);
    stop();
    ok = (a === 3'h0);
  endtask : read_word
endmodule : csw_host_model

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) check(16'(g), 16'(e))
module tb;
  import csw_pkg::*;
  logic clk_sys_in;
  logic smb_clk_in;
  logic reset_in;
  csw_cmp_type cmp;  // comparator levels
  logic scl;
  logic host_low;
  logic sda_out;
  logic sda_oe;
  logic flag, gate, en;
  logic [15:0] eff, cur_o, vol_o, inp_o, word;
  logic [15:0] cur, vol, inp;  // model setpoints
  logic clamp;  // model undervoltage clamp
  int errors;
  int checked;
  int seed_v;
  // open-drain data line with pull-up
  wire sda = ~(host_low | (sda_oe & ~sda_out));
  csw_charger dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .cmp_in(cmp),
    .smb_clk_in(smb_clk_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe), .adapter_present_flag_out(flag), .source_switch_gate_out(gate),
    .charge_enable_out(en), .effective_current_out(eff), .current_setpoint_out(cur_o),
    .voltage_setpoint_out(vol_o), .input_limit_out(inp_o), .charger_state_word_out(word));
  csw_host_model host (.clk_in(clk_sys_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(host_low));
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // link clock, phase offset from the system clock
  initial begin
    smb_clk_in = 1'b0;
    #3.3;
    forever #16 smb_clk_in = ~smb_clk_in;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // model update, then every output but the data line against it after sync delay
  task automatic expect_outputs;
    repeat (12) @(negedge clk_sys_in);
    if (cmp.battery_voltage_sense_below_uv) clamp = 1'b1;
    else if (cmp.battery_voltage_sense_above_release) clamp = 1'b0;
    if (cmp.logic_supply_uv) begin
      cur = CSW_CURRENT_RST;
      vol = CSW_VOLTAGE_RST;
      inp = CSW_INPUT_RST;
    end
    `CHK(word, {cmp.adapter_above, cmp.thermistor_low, cmp.adapter_below_battery_voltage_sense, 13'h0});
    `CHK(flag, cmp.adapter_above);
    `CHK(gate, cmp.adapter_above & ~cmp.adapter_below_battery_voltage_sense);
    `CHK(en, cmp.adapter_above & ~cmp.adapter_below_battery_voltage_sense & ~cmp.logic_supply_uv
      & (vol >= CSW_VOLTAGE_MIN));
    `CHK(eff, clamp ? CSW_UV_CURRENT : cur);
    `CHK(cur_o, cur);
    `CHK(inp_o, inp);
    `CHK(vol_o, vol);
  endtask : expect_outputs
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    input logic e);
    logic ok;
    host.write_word(a, c, d, ok);
    `CHK(ok, e);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic ok;
    logic [15:0] d;
    host.read_word(CSW_SLAVE_ADDR, c, d, ok);
    `CHK(ok, 1'b1);
    `CHK(d, e);
  endtask : rd
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    cmp = '0;
    reset_in = 1'b1;
    clamp = 1'b0;
    cur = CSW_CURRENT_RST;
    vol = CSW_VOLTAGE_RST;
    inp = CSW_INPUT_RST;
    seed_v = $urandom(32'h81c2);
    repeat (4) @(negedge clk_sys_in);
    reset_in = 1'b0;
    expect_outputs();
    // setpoints with the adapter absent
    cur = 16'($urandom);
    vol = 16'($urandom);
    inp = 16'($urandom);
    wr(CSW_SLAVE_ADDR, CSW_CMD_CURRENT, cur, 1'b1);
    wr(CSW_SLAVE_ADDR, CSW_CMD_VOLTAGE, vol, 1'b1);
    wr(CSW_SLAVE_ADDR, CSW_CMD_INPUT, inp, 1'b1);
    rd(CSW_CMD_CURRENT, cur);
    rd(CSW_CMD_VOLTAGE, vol);
    rd(CSW_CMD_INPUT, inp);
    // every adapter and thermistor combination
    for (int i = 0; i < 8; i++) begin
      cmp.adapter_above = i[0];
      cmp.adapter_below_battery_voltage_sense = i[1];
      cmp.thermistor_low = i[2];
      expect_outputs();
    end
    // state word is read only: write is dropped
    wr(CSW_SLAVE_ADDR, CSW_CMD_STATE_DEF, 16'hffff, 1'b1);
    rd(CSW_CMD_STATE_DEF, 16'he000);
    // battery undervoltage clamp and its hysteresis
    cmp = '0;
    cmp.adapter_above = 1'b1;
    cmp.battery_voltage_sense_below_uv = 1'b1;
    expect_outputs();
    vol = CSW_VOLTAGE_MIN;
    wr(CSW_SLAVE_ADDR, CSW_CMD_VOLTAGE, vol, 1'b1);
    rd(CSW_CMD_VOLTAGE, vol);
    expect_outputs();
    cmp.battery_voltage_sense_below_uv = 1'b0;
    expect_outputs();
    cmp.battery_voltage_sense_above_release = 1'b1;
    expect_outputs();
    wr(CSW_SLAVE_ADDR ^ 7'h01, CSW_CMD_CURRENT, 16'h1234, 1'b0);
    // logic supply undervoltage: silent bus, defaults after recovery
    cmp.logic_supply_uv = 1'b1;
    expect_outputs();
    wr(CSW_SLAVE_ADDR, CSW_CMD_CURRENT, 16'($urandom), 1'b0);
    cmp.logic_supply_uv = 1'b0;
    expect_outputs();
    results();
  end
  // hang guard, well beyond the run of about 262 us, under the cycle budget
  initial begin
    #450000;
    errors++;
    results();
  end
endmodule : tb
